// ===== design/pcs_top.sv
/*
  Prefetch cache statistics: hit, miss and prefetch-abort counters
  behind an AHB-Lite slave with zero wait states.
  Assumes cache event strobes are one-cycle pulses on CLK.
*/
module pcs_top
  import pcs_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic EV_HIT,
  input wire logic EV_MISS,
  input wire logic EV_IFETCH,
  input wire logic EV_CACHEABLE,
  input wire logic EV_PF_ABORT
);

  // ----------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------
  logic wr_pend_r;
  pcs_sel_t wr_sel_r;
  logic [31:0] rdata_r;
  logic hreadyout_r;
  logic hresp_r;
  logic [31:0] hit_cnt;
  logic [31:0] miss_cnt;
  logic [31:0] abort_cnt;
  logic inc_hit;
  logic inc_miss;
  logic ld_hit;
  logic ld_miss;
  logic ld_abort;
  logic acc;
  pcs_sel_t asel;

  pcs_wr_if wr_bus ();

  assign acc = HSEL && HREADY && (HTRANS == PCS_HTRANS_NONSEQ || HTRANS == PCS_HTRANS_SEQ);
  assign asel = pcs_decode(HADDR[PCS_AW-1:0]);

  // Remember a write for its data phase
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      wr_pend_r <= 1'b0;
      wr_sel_r <= PCS_SEL_NONE;
    end else begin
      wr_pend_r <= acc && HWRITE;
      wr_sel_r <= asel;
    end
  end

  // Read data registered at the address phase
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      rdata_r <= PCS_RD_ZERO;
    end else if (acc && !HWRITE) begin
      case (asel)
        PCS_SEL_HIT: rdata_r <= hit_cnt;
        PCS_SEL_MISS: rdata_r <= miss_cnt;
        PCS_SEL_ABORT: rdata_r <= abort_cnt;
        default: rdata_r <= PCS_RD_ZERO;
      endcase
    end
  end

  // Zero wait state, always OKAY; kept in flops so outputs are registered
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
  end

  assign HRDATA = rdata_r;
  assign HREADYOUT = hreadyout_r;
  assign HRESP = hresp_r;

  // ----------------------------------------------------------------
  // Write path to counters
  // ----------------------------------------------------------------
  assign wr_bus.wr_en = wr_pend_r;
  assign wr_bus.wr_sel = wr_sel_r;
  assign wr_bus.wr_data = HWDATA;

  assign ld_hit = wr_bus.wr_en && wr_bus.wr_sel == PCS_SEL_HIT;
  assign ld_miss = wr_bus.wr_en && wr_bus.wr_sel == PCS_SEL_MISS;
  assign ld_abort = wr_bus.wr_en && wr_bus.wr_sel == PCS_SEL_ABORT;

  // ----------------------------------------------------------------
  // Event qualification
  // ----------------------------------------------------------------
  assign inc_hit = EV_HIT && EV_CACHEABLE;
  assign inc_miss = EV_MISS && EV_CACHEABLE && EV_IFETCH;

  // Hit counter
  pcs_counter u_hit (
    .clk(CLK),
    .rstn(RSTN),
    .inc(inc_hit),
    .ld(ld_hit),
    .ld_data(wr_bus.wr_data),
    .cnt(hit_cnt)
  );

  // Miss counter
  pcs_counter u_miss (
    .clk(CLK),
    .rstn(RSTN),
    .inc(inc_miss),
    .ld(ld_miss),
    .ld_data(wr_bus.wr_data),
    .cnt(miss_cnt)
  );

  // Prefetch abort counter
  pcs_counter u_abort (
    .clk(CLK),
    .rstn(RSTN),
    .inc(EV_PF_ABORT),
    .ld(ld_abort),
    .ld_data(wr_bus.wr_data),
    .cnt(abort_cnt)
  );

  // Size is accepted as a word; other sizes are not expected
  logic unused_ok;
  assign unused_ok = ^{HSIZE, HADDR[31:PCS_AW]};

endmodule : pcs_top

// ===== design/pcs_pkg.sv
/*
  Package for the prefetch cache statistics block: register offsets,
  widths and shared helpers.
  Assumes a single 50 MHz clock domain and an AHB-Lite register bus.
*/
// Summary of operation
// - Hit counter adds one per cacheable fetch or load that hits.
// - Non-cacheable accesses change neither hit nor miss counter.
// - Miss counter adds one per cacheable instruction fetch miss only.
// - Abort counter adds one per cancelled automatic prefetch.
// - Each counter is 32 bits, fully readable and writable by software.
package pcs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int PCS_AW = 4;
  localparam logic [3:0] PCS_OFS_HIT = 4'h0;
  localparam logic [3:0] PCS_OFS_MISS = 4'h4;
  localparam logic [3:0] PCS_OFS_ABORT = 4'h8;
  localparam int PCS_CNT_W = 32;
  localparam logic [31:0] PCS_CNT_RST = 32'h0000_0000;
  localparam logic [31:0] PCS_RD_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // AHB-Lite codes
  // ----------------------------------------------------------------
  localparam logic [1:0] PCS_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] PCS_HTRANS_SEQ = 2'h3;
  localparam logic [2:0] PCS_HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    PCS_SEL_HIT,
    PCS_SEL_MISS,
    PCS_SEL_ABORT,
    PCS_SEL_NONE
  } pcs_sel_t;

  // Address to counter select
  function automatic pcs_sel_t pcs_decode(input logic [3:0] ofs);
    pcs_sel_t s;
    s = PCS_SEL_NONE;
    case (ofs)
      PCS_OFS_HIT: s = PCS_SEL_HIT;
      PCS_OFS_MISS: s = PCS_SEL_MISS;
      PCS_OFS_ABORT: s = PCS_SEL_ABORT;
      default: s = PCS_SEL_NONE;
    endcase
    return s;
  endfunction : pcs_decode

endpackage : pcs_pkg

// ===== design/pcs_wr_if.sv
/*
  Interface carrying a decoded register write from the bus slave to
  the counters. Assumes both ends run on the same clock.
*/
interface pcs_wr_if;
  import pcs_pkg::*;
  logic wr_en;
  pcs_sel_t wr_sel;
  logic [31:0] wr_data;
  modport src (output wr_en, output wr_sel, output wr_data);
  modport dst (input wr_en, input wr_sel, input wr_data);
endinterface : pcs_wr_if

// ===== design/pcs_counter.sv
/*
  One 32-bit statistics counter with software load.
  Assumes the event strobe is one cycle per event from same-clock logic.
*/
module pcs_counter
  import pcs_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic inc,
  input wire logic ld,
  input wire logic [31:0] ld_data,
  output logic [31:0] cnt
);

  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;

  // Write beats increment; increment wraps naturally
  always_comb begin
    cnt_nxt = cnt_r;
    if (ld) begin
      cnt_nxt = ld_data;
    end else if (inc) begin
      cnt_nxt = cnt_r + 32'h0000_0001;
    end
  end

  // Counter register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_r <= PCS_CNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign cnt = cnt_r;

endmodule : pcs_counter

// ===== verification/pcs_chk_assertions.sv
/* Port checker for pcs_top.
   Assumes zero-wait slave, HREADY tied to HREADYOUT. */
module pcs_chk
  import pcs_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic [31:0] HRDATA,
  input wire logic EV_HIT,
  input wire logic EV_MISS,
  input wire logic EV_IFETCH,
  input wire logic EV_CACHEABLE,
  input wire logic EV_PF_ABORT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Access and event decode
  logic rd, wr, h, m;
  logic [3:0] a;
  assign a = HADDR[3:0];
  assign rd = HSEL & HTRANS[1] & !HWRITE;
  assign wr = HSEL & HTRANS[1] & HWRITE;
  assign h = EV_HIT & EV_CACHEABLE;
  assign m = EV_MISS & EV_CACHEABLE & EV_IFETCH;
  property p_hit;
    !$past(wr) && rd && a == 4'h0 && h ##1 !h ##1 rd && a == 4'h0
      |=> HRDATA == $past(HRDATA) + 32'h1;
  endproperty
  a_hit: assert property (p_hit) else $error("hit count step");
  property p_hold;
    !$past(wr) && rd && a == 4'h4 && !m ##1 !m ##1 rd && a == 4'h4 |=> $stable(HRDATA);
  endproperty
  a_hold: assert property (p_hold) else $error("miss count moved");
  property p_miss;
    !$past(wr) && rd && a == 4'h4 && m ##1 !m ##1 rd && a == 4'h4
      |=> HRDATA == $past(HRDATA) + 32'h1;
  endproperty
  a_miss: assert property (p_miss) else $error("miss count step");
  property p_abt;
    !$past(wr) && rd && a == 4'h8 && EV_PF_ABORT ##1 !EV_PF_ABORT ##1 rd && a == 4'h8
      |=> HRDATA == $past(HRDATA) + 32'h1;
  endproperty
  a_abt: assert property (p_abt) else $error("abort count step");
  property p_wr;
    wr && a inside {4'h0, 4'h4, 4'h8} ##1 !HTRANS[1] ##1 rd && a == $past(a, 2)
      |=> HRDATA == $past(HWDATA, 2);
  endproperty
  a_wr: assert property (p_wr) else $error("write not read back");
  property p_unm;
    rd && !(a inside {4'h0, 4'h4, 4'h8}) |=> HRDATA == 32'h0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  cover property (rd && a == 4'h0 && h);
  cover property (wr ##1 h);
  cover property (rd && a == 4'hc);
endmodule : pcs_chk

bind pcs_top pcs_chk u_chk(.CLK, .RSTN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA, .HRDATA,
  .EV_HIT, .EV_MISS, .EV_IFETCH, .EV_CACHEABLE, .EV_PF_ABORT);

// ===== verification/pcs_cpu_model.sv
/* Event source for the fetch and load path.
   Assumes the bench steps cmd just after a rising edge. */
module pcs_cpu_model (
  input wire logic [4:0] cmd,
  output logic hit,
  output logic miss,
  output logic ifetch,
  output logic cacheable,
  output logic abort
);
  // One cycle of cmd gives one event
  assign {abort, cacheable, ifetch, miss, hit} = cmd;
endmodule : pcs_cpu_model

// ===== verification/testbench.sv
/* Self-checking bench for pcs_top.
   Assumes the checker and event model are compiled first. */
module testbench
  import pcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, hsel = 0, hw = 0, rdy, resp;
  logic [1:0] ht = 2'h0;
  logic [31:0] ha = 32'h0, wd = 32'h0, rdat, q;
  logic [4:0] evc = 5'h0, evd = 5'h0;
  logic e_hit, e_miss, e_if, e_ca, e_ab;
  int n_mismatch = 0, checks_done = 0;
  typedef struct {logic [3:0] a; logic [4:0] ev; logic [31:0] pre, exp;} pcs_row_t;
  // Offset, events {abort,cache,fetch,miss,hit}, preset, expected
  pcs_row_t rows[9] = '{'{PCS_OFS_HIT, 5'h09, 32'h5, 32'h6}, '{PCS_OFS_HIT, 5'h0d, 32'h5, 32'h6},
    '{PCS_OFS_HIT, 5'h01, 32'h5, 32'h5}, '{PCS_OFS_MISS, 5'h0e, 32'h5, 32'h6},
    '{PCS_OFS_MISS, 5'h0a, 32'h5, 32'h5}, '{PCS_OFS_MISS, 5'h06, 32'h5, 32'h5},
    '{PCS_OFS_ABORT, 5'h10, 32'h5, 32'h6}, '{PCS_OFS_HIT, 5'h09, 32'hffffffff, 32'h0},
    '{4'hc, 5'h1f, 32'h5, 32'h0}};
  pcs_top dut(.CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(ha), .HTRANS(ht), .HWRITE(hw),
    .HSIZE(PCS_HSIZE_WORD), .HREADY(rdy), .HWDATA(wd), .HRDATA(rdat), .HREADYOUT(rdy),
    .HRESP(resp), .EV_HIT(e_hit), .EV_MISS(e_miss), .EV_IFETCH(e_if), .EV_CACHEABLE(e_ca),
    .EV_PF_ABORT(e_ab));
  pcs_cpu_model u_cpu(.cmd(evc), .hit(e_hit), .miss(e_miss), .ifetch(e_if),
    .cacheable(e_ca), .abort(e_ab));
  initial forever #10 clk = ~clk;
  task automatic summarize;
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  // Bounded wait for hready
  task automatic hwait;
    int n;
    n = 0;
    @(posedge clk);
    while (rdy !== 1'b1) begin
      if (++n > 50) begin
        n_mismatch++;
        summarize();
      end
      @(posedge clk);
    end
  endtask : hwait
  // One single AHB transfer
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel <= 1'b1;
    ht <= PCS_HTRANS_NONSEQ;
    hw <= w;
    ha <= {28'h0, a};
    hwait();
    ht <= 2'h0;
    evc <= evd;
    wd <= d;
    hwait();
    r = rdat;
  endtask : xfer
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].a, rows[i].pre, q);
      evc <= rows[i].ev;
      xfer(1'b0, rows[i].a, 32'h0, q);
      xfer(1'b0, rows[i].a, 32'h0, q);
      chk("hrdata", q, rows[i].exp);
    end
    // Write and hit event in the same cycle
    evd = 5'h09;
    xfer(1'b1, PCS_OFS_HIT, 32'h1234, q);
    evd = 5'h0;
    xfer(1'b0, PCS_OFS_HIT, 32'h0, q);
    chk("write vs hit", q, 32'h1234);
    // Mid-run reset: bus stays ready and OKAY, counters restart
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    chk("hreadyout", {31'h0, rdy}, 32'h1);
    chk("hresp", {31'h0, resp}, 32'h0);
    rstn <= 1'b1;
    xfer(1'b0, PCS_OFS_HIT, 32'h0, q);
    chk("hit after reset", q, PCS_CNT_RST);
    chk("hresp after reset", {31'h0, resp}, 32'h0);
    summarize();
  end
endmodule : testbench
